// File: hw/csr_defs.vh
// Behaviour
// - first status register shows taper, done, current limit, power path, vin regulation, thermal
// - power good bit set only when input above lockout, above battery+margin, below overvoltage
// - second register bit 7 input overvoltage, bit 5 battery overcurrent, live
// - second register bit 4 set while battery is below its lockout level
// - bit 2 set in cool zone; charge current reduced there
// - bit 1 set in warm zone; regulation voltage reduced there
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH

// register offsets
`define CSR_OFS_CHARGE_PATH 8'h00
`define CSR_OFS_FAULT_TEMP 8'h01

// charge_path_status fields
`define CSR_CP_RSVD 7
`define CSR_CP_TAPER 6
`define CSR_CP_DONE 5
`define CSR_CP_ILIM 4
`define CSR_CP_DPPM 3
`define CSR_CP_VINREG 2
`define CSR_CP_THERM 1
`define CSR_CP_PGOOD 0

// fault_temperature_status fields
`define CSR_FT_OVP 7
`define CSR_FT_RSVD 6
`define CSR_FT_OCP 5
`define CSR_FT_BUVLO 4
`define CSR_FT_COLD 3
`define CSR_FT_COOL 2
`define CSR_FT_WARM 1
`define CSR_FT_HOT 0

// values seen after reset and for unmapped reads
`define CSR_RST_STATUS 8'h00
`define CSR_UNMAPPED_DATA 8'h00

// 7-bit target address on the serial bus; arbitrary value
`define CSR_DEV_ADDR 7'h3A

// bits per serial byte
`define CSR_BYTE_BITS 4'h8

`endif

// File: hw/csr_status_eval.v
`timescale 1ns/10ps
`include "csr_defs.vh"

module csr_status_eval (
  input wire clk_i, // device clock
  input wire rst_n_i, // async reset, active low
  input wire taper_phase_active_i, // constant-voltage taper phase
  input wire charge_done_i, // termination reached
  input wire input_current_limit_active_i, // input current loop active
  input wire power_path_mgmt_active_i, // power-path loop active
  input wire input_voltage_regulation_active_i, // input voltage loop active
  input wire thermal_regulation_active_i, // die thermal loop active
  input wire vin_above_lockout_i, // input above input_lockout_threshold
  input wire vin_above_bat_margin_i, // input above battery + sleep_margin_voltage
  input wire vin_below_ovp_i, // input below input_overvoltage_threshold
  input wire input_overvoltage_fault_i, // input overvoltage comparator
  input wire battery_overcurrent_fault_i, // battery overcurrent protection
  input wire bat_below_lockout_i, // battery below battery_lockout_level
  input wire ts_above_cold_i, // sense voltage above cold threshold
  input wire ts_above_cool_i, // sense voltage above cool threshold
  input wire ts_below_warm_i, // sense voltage below warm threshold
  input wire ts_below_hot_i, // sense voltage below hot threshold
  output reg [7:0] charge_path_q_o, // first status register
  output reg [7:0] fault_temp_q_o, // second status register
  output reg suspend_q_o, // charging suspended by temperature
  output reg current_reduce_q_o, // charge current reduction request
  output reg voltage_reduce_q_o // regulation voltage reduction request
);

  reg [7:0] charge_path_d;
  reg [7:0] fault_temp_d;

  // live condition decode; zones are mutually exclusive by threshold order
  always @* begin
    charge_path_d = `CSR_RST_STATUS;
    fault_temp_d = `CSR_RST_STATUS;
    charge_path_d[`CSR_CP_TAPER] = taper_phase_active_i;
    charge_path_d[`CSR_CP_DONE] = charge_done_i;
    charge_path_d[`CSR_CP_ILIM] = input_current_limit_active_i;
    charge_path_d[`CSR_CP_DPPM] = power_path_mgmt_active_i;
    charge_path_d[`CSR_CP_VINREG] = input_voltage_regulation_active_i;
    charge_path_d[`CSR_CP_THERM] = thermal_regulation_active_i;
    charge_path_d[`CSR_CP_PGOOD] = vin_above_lockout_i & vin_above_bat_margin_i
                                   & vin_below_ovp_i;
    fault_temp_d[`CSR_FT_OVP] = input_overvoltage_fault_i;
    fault_temp_d[`CSR_FT_OCP] = battery_overcurrent_fault_i;
    fault_temp_d[`CSR_FT_BUVLO] = bat_below_lockout_i;
    fault_temp_d[`CSR_FT_COLD] = ts_above_cold_i;
    fault_temp_d[`CSR_FT_COOL] = ts_above_cool_i & ~ts_above_cold_i;
    fault_temp_d[`CSR_FT_WARM] = ts_below_warm_i & ~ts_below_hot_i;
    fault_temp_d[`CSR_FT_HOT] = ts_below_hot_i;
  end

  // sample every clock; reserved bits stay zero since _d never sets them
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      charge_path_q_o <= `CSR_RST_STATUS;
      fault_temp_q_o <= `CSR_RST_STATUS;
      suspend_q_o <= 1'b0;
      current_reduce_q_o <= 1'b0;
      voltage_reduce_q_o <= 1'b0;
    end else begin
      charge_path_q_o <= charge_path_d;
      fault_temp_q_o <= fault_temp_d;
      suspend_q_o <= fault_temp_d[`CSR_FT_COLD] | fault_temp_d[`CSR_FT_HOT];
      current_reduce_q_o <= fault_temp_d[`CSR_FT_COOL];
      voltage_reduce_q_o <= fault_temp_d[`CSR_FT_WARM];
    end
  end

endmodule // csr_status_eval

// File: hw/csr_status_top.v
`timescale 1ns/10ps
`include "csr_defs.vh"

module csr_status_top (
  input wire CLOCK_I, // device clock, 125 MHz
  input wire RST_N_I, // async reset, active low
  input wire SCL_I, // serial clock level
  input wire SDA_I, // serial data level
  output reg SDA_O, // serial data drive value, always low
  output reg SDA_OE_N_O, // low while pulling data line low
  input wire TAPER_PHASE_ACTIVE_I, // taper phase active
  input wire CHARGE_DONE_I, // charge terminated
  input wire INPUT_CURRENT_LIMIT_ACTIVE_I, // input current limit active
  input wire POWER_PATH_MGMT_ACTIVE_I, // power-path management active
  input wire INPUT_VOLTAGE_REGULATION_ACTIVE_I, // input voltage loop active
  input wire THERMAL_REGULATION_ACTIVE_I, // thermal loop active
  input wire VIN_ABOVE_LOCKOUT_I, // input above lockout
  input wire VIN_ABOVE_BAT_MARGIN_I, // input above battery plus margin
  input wire VIN_BELOW_OVP_I, // input below overvoltage limit
  input wire INPUT_OVERVOLTAGE_FAULT_I, // input overvoltage fault
  input wire BATTERY_OVERCURRENT_FAULT_I, // battery overcurrent fault
  input wire BAT_BELOW_LOCKOUT_I, // battery below lockout level
  input wire TS_ABOVE_COLD_I, // sense above cold threshold
  input wire TS_ABOVE_COOL_I, // sense above cool threshold
  input wire TS_BELOW_WARM_I, // sense below warm threshold
  input wire TS_BELOW_HOT_I, // sense below hot threshold
  output wire CHARGE_SUSPEND_O, // charging suspended, cold or hot
  output wire CURRENT_REDUCE_O, // reduce charge current, cool zone
  output wire VOLTAGE_REDUCE_O, // reduce regulation voltage, warm zone
  output wire [7:0] CHARGE_PATH_STATUS_O, // first status register contents
  output wire [7:0] FAULT_TEMP_STATUS_O // second status register contents
);

  // serial engine states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_AACK = 3'h2;
  localparam [2:0] ST_WBYTE = 3'h3;
  localparam [2:0] ST_WACK = 3'h4;
  localparam [2:0] ST_RBYTE = 3'h5;
  localparam [2:0] ST_RACK = 3'h6;

  wire [7:0] charge_path_w;
  wire [7:0] fault_temp_w;
  wire [7:0] rd_w;
  reg scl_q;
  reg sda_q;
  reg scl_p_q;
  reg sda_p_q;
  reg [2:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg [7:0] ptr_q;
  reg rw_q;
  reg first_q;
  reg nack_q;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;

  // register read decode; used for the first byte and every follow-on byte
  function [7:0] rd_reg;
    input [7:0] idx;
    input [7:0] cp;
    input [7:0] ft;
    begin
      case (idx)
        `CSR_OFS_CHARGE_PATH: rd_reg = cp;
        `CSR_OFS_FAULT_TEMP: rd_reg = ft;
        default: rd_reg = `CSR_UNMAPPED_DATA;
      endcase
    end
  endfunction

  // status sampling and temperature actions
  csr_status_eval u_eval (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .taper_phase_active_i(TAPER_PHASE_ACTIVE_I),
    .charge_done_i(CHARGE_DONE_I),
    .input_current_limit_active_i(INPUT_CURRENT_LIMIT_ACTIVE_I),
    .power_path_mgmt_active_i(POWER_PATH_MGMT_ACTIVE_I),
    .input_voltage_regulation_active_i(INPUT_VOLTAGE_REGULATION_ACTIVE_I),
    .thermal_regulation_active_i(THERMAL_REGULATION_ACTIVE_I),
    .vin_above_lockout_i(VIN_ABOVE_LOCKOUT_I),
    .vin_above_bat_margin_i(VIN_ABOVE_BAT_MARGIN_I),
    .vin_below_ovp_i(VIN_BELOW_OVP_I),
    .input_overvoltage_fault_i(INPUT_OVERVOLTAGE_FAULT_I),
    .battery_overcurrent_fault_i(BATTERY_OVERCURRENT_FAULT_I),
    .bat_below_lockout_i(BAT_BELOW_LOCKOUT_I),
    .ts_above_cold_i(TS_ABOVE_COLD_I),
    .ts_above_cool_i(TS_ABOVE_COOL_I),
    .ts_below_warm_i(TS_BELOW_WARM_I),
    .ts_below_hot_i(TS_BELOW_HOT_I),
    .charge_path_q_o(charge_path_w),
    .fault_temp_q_o(fault_temp_w),
    .suspend_q_o(CHARGE_SUSPEND_O),
    .current_reduce_q_o(CURRENT_REDUCE_O),
    .voltage_reduce_q_o(VOLTAGE_REDUCE_O)
  );

  // register contents mirrored straight from the sampling flops
  assign CHARGE_PATH_STATUS_O = charge_path_w;
  assign FAULT_TEMP_STATUS_O = fault_temp_w;

  // byte at the pointer; its top bit goes out first, so it is picked by index
  assign rd_w = rd_reg(ptr_q, charge_path_w, fault_temp_w);

  // pins are synchronous; one stage plus a history stage for edge finding
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_q <= SCL_I;
      sda_q <= SDA_I;
      scl_p_q <= scl_q;
      sda_p_q <= sda_q;
    end
  end

  // line events; data changing while clock high marks frame bounds
  assign scl_rise = scl_q & ~scl_p_q;
  assign scl_fall = ~scl_q & scl_p_q;
  assign start_det = scl_q & scl_p_q & sda_p_q & ~sda_q;
  assign stop_det = scl_q & scl_p_q & ~sda_p_q & sda_q;

  // serial target engine; data is driven only after a clock fall so the
  // line is stable for the whole high phase the host samples
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      nack_q <= 1'b0;
      SDA_O <= 1'b0;
      SDA_OE_N_O <= 1'b1;
    end else begin
      SDA_O <= 1'b0;
      if (start_det) begin
        // a repeated start also lands here, keeping the pointer
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        SDA_OE_N_O <= 1'b1;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        SDA_OE_N_O <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            SDA_OE_N_O <= 1'b1;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == `CSR_BYTE_BITS) begin
              cnt_q <= 4'h0;
              if (shift_q[7:1] == `CSR_DEV_ADDR) begin
                rw_q <= shift_q[0];
                SDA_OE_N_O <= 1'b0;
                state_q <= ST_AACK;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                // reading has no side effect beyond the pointer
                tx_q <= rd_w;
                SDA_OE_N_O <= rd_w[7];
                ptr_q <= ptr_q + 8'h01;
                state_q <= ST_RBYTE;
              end else begin
                SDA_OE_N_O <= 1'b1;
                first_q <= 1'b1;
                state_q <= ST_WBYTE;
              end
            end
          end
          ST_WBYTE: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == `CSR_BYTE_BITS) begin
              // first byte sets the pointer; data bytes are acked and dropped
              if (first_q) begin
                ptr_q <= shift_q;
              end
              first_q <= 1'b0;
              cnt_q <= 4'h0;
              SDA_OE_N_O <= 1'b0;
              state_q <= ST_WACK;
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              SDA_OE_N_O <= 1'b1;
              state_q <= ST_WBYTE;
            end
          end
          ST_RBYTE: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == `CSR_BYTE_BITS) begin
                cnt_q <= 4'h0;
                SDA_OE_N_O <= 1'b1;
                state_q <= ST_RACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                SDA_OE_N_O <= tx_q[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_q <= sda_q;
            end else if (scl_fall) begin
              if (nack_q) begin
                // host is done; line stays released until stop
                state_q <= ST_IDLE;
              end else begin
                tx_q <= rd_w;
                SDA_OE_N_O <= rd_w[7];
                ptr_q <= ptr_q + 8'h01;
                state_q <= ST_RBYTE;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
            SDA_OE_N_O <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // csr_status_top

// File: verif/csr_status_properties.sv
`timescale 1ns/10ps
module csr_status_props (
  input wire CLOCK_I, // device clock
  input wire RST_N_I, // async reset, active low
  input wire SDA_O, // data drive value
  input wire SDA_OE_N_O, // low while pulling data
  input wire TAPER_PHASE_ACTIVE_I, // taper phase
  input wire CHARGE_DONE_I, // charge done
  input wire INPUT_CURRENT_LIMIT_ACTIVE_I, // current loop
  input wire POWER_PATH_MGMT_ACTIVE_I, // power-path loop
  input wire INPUT_VOLTAGE_REGULATION_ACTIVE_I, // input voltage loop
  input wire THERMAL_REGULATION_ACTIVE_I, // thermal loop
  input wire VIN_ABOVE_LOCKOUT_I, // input above lockout
  input wire VIN_ABOVE_BAT_MARGIN_I, // input above battery plus margin
  input wire VIN_BELOW_OVP_I, // input below overvoltage
  input wire INPUT_OVERVOLTAGE_FAULT_I, // input overvoltage
  input wire BATTERY_OVERCURRENT_FAULT_I, // battery overcurrent
  input wire BAT_BELOW_LOCKOUT_I, // battery low
  input wire TS_ABOVE_COLD_I, // sense above cold
  input wire TS_ABOVE_COOL_I, // sense above cool
  input wire TS_BELOW_WARM_I, // sense below warm
  input wire TS_BELOW_HOT_I, // sense below hot
  input wire CHARGE_SUSPEND_O, // suspend request
  input wire CURRENT_REDUCE_O, // current reduction request
  input wire VOLTAGE_REDUCE_O, // voltage reduction request
  input wire [7:0] CHARGE_PATH_STATUS_O, // first status register
  input wire [7:0] FAULT_TEMP_STATUS_O // second status register
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  // expected words, judged one edge late; skip the first edge after reset
  wire [7:0] cp = CHARGE_PATH_STATUS_O;
  wire [7:0] ft = FAULT_TEMP_STATUS_O;
  wire [7:0] cp_exp = {1'b0, TAPER_PHASE_ACTIVE_I, CHARGE_DONE_I, INPUT_CURRENT_LIMIT_ACTIVE_I,
    POWER_PATH_MGMT_ACTIVE_I, INPUT_VOLTAGE_REGULATION_ACTIVE_I, THERMAL_REGULATION_ACTIVE_I,
    VIN_ABOVE_LOCKOUT_I & VIN_ABOVE_BAT_MARGIN_I & VIN_BELOW_OVP_I};
  wire [7:0] ft_exp = {INPUT_OVERVOLTAGE_FAULT_I, 1'b0, BATTERY_OVERCURRENT_FAULT_I, 5'h00};
  a_loop_bits_live: assert property ($past(RST_N_I) |->
    ((cp ^ $past(cp_exp)) & 8'h7E) == 8'h00) else $error("loop status bits wrong");
  a_power_good_and: assert property ($past(RST_N_I) |->
    cp[0] == $past(cp_exp[0])) else $error("power good bit wrong");
  a_fault_bits_live: assert property ($past(RST_N_I) |->
    ((ft ^ $past(ft_exp)) & 8'hA0) == 8'h00) else $error("fault bits wrong");
  a_battery_low_bit: assert property ($past(RST_N_I) |->
    ft[4] == $past(BAT_BELOW_LOCKOUT_I)) else $error("battery low bit wrong");
  a_cold_suspends: assert property (TS_ABOVE_COLD_I |=>
    ft[3] && !ft[2] && CHARGE_SUSPEND_O) else $error("cold zone wrong");
  a_cool_reduces: assert property (TS_ABOVE_COOL_I && !TS_ABOVE_COLD_I |=>
    ft[2] && CURRENT_REDUCE_O && !ft[3]) else $error("cool zone wrong");
  a_warm_reduces: assert property (TS_BELOW_WARM_I && !TS_BELOW_HOT_I |=>
    ft[1] && VOLTAGE_REDUCE_O && !ft[0]) else $error("warm zone wrong");
  a_hot_suspends: assert property (TS_BELOW_HOT_I |=>
    ft[0] && !ft[1] && CHARGE_SUSPEND_O) else $error("hot zone wrong");
  a_requests_match: assert property (
    {CHARGE_SUSPEND_O, CURRENT_REDUCE_O, VOLTAGE_REDUCE_O} == {ft[3] | ft[0], ft[2], ft[1]})
    else $error("zone requests disagree with status");
  a_reserved_zero: assert property (!cp[7] && !ft[6]) else $error("reserved bit set");
  // open drain: the line may only ever be pulled low
  a_drive_value_low: assert property (!SDA_O) else $error("data drive value not low");
  // main scenarios reached
  cover property (ft[3] && CHARGE_SUSPEND_O);
  cover property (cp[0]);
  cover property ($fell(SDA_OE_N_O));
endmodule // csr_status_props

// File: verif/csr_i2c_host.sv
`timescale 1ns/10ps
// serial host: frames, bytes MSB first, ninth clock carries the ack
module csr_i2c_host (
  input wire clk_i, // bench clock
  input wire sda_i, // resolved data line
  output reg scl_o, // serial clock, idles high
  output reg sda_pull_o // 1 pulls data low
);
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // five clocks a phase, above the four the device needs
  task half;
    repeat (5) @(negedge clk_i);
  endtask
  task start;
    begin
      half;
      sda_pull_o = 1'b0;
      half;
      scl_o = 1'b1;
      half;
      sda_pull_o = 1'b1;
      half;
      scl_o = 1'b0;
    end
  endtask
  task stop;
    begin
      half;
      sda_pull_o = 1'b1;
      half;
      scl_o = 1'b1;
      half;
      sda_pull_o = 1'b0;
      half;
    end
  endtask
  // data moves well after the clock fall so it never looks like start or stop
  task clk_bit(input b, output s);
    begin
      repeat (2) @(negedge clk_i);
      sda_pull_o = ~b;
      half;
      scl_o = 1'b1;
      half;
      s = sda_i;
      scl_o = 1'b0;
    end
  endtask
  task xfer(input [7:0] tx, input ackb, output [7:0] rx, output ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) clk_bit(tx[i], rx[i]);
      clk_bit(ackb, ack);
    end
  endtask
endmodule // csr_i2c_host

// File: verif/tb_csr_status_top.sv
`timescale 1ns/10ps
`include "csr_defs.vh"
module tb_csr_status_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [15:0] st = 16'h0000; // status inputs in register bit order
  reg [7:0] d0;
  reg [7:0] d1;
  reg a;
  wire scl;
  wire pull;
  wire oe_n;
  wire sdo;
  wire sda = (oe_n | sdo) & ~pull; // pull-up wins when nobody pulls
  wire [2:0] zone;
  wire [7:0] cp;
  wire [7:0] ft;
  integer failures = 0;
  integer comparisons = 0;
  always #4 clk = ~clk;
  csr_i2c_host csr_i2c_host_i (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
  csr_status_top csr_status_top_i (.CLOCK_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sdo), .SDA_OE_N_O(oe_n), .TAPER_PHASE_ACTIVE_I(st[15]), .CHARGE_DONE_I(st[14]),
    .INPUT_CURRENT_LIMIT_ACTIVE_I(st[13]), .POWER_PATH_MGMT_ACTIVE_I(st[12]),
    .INPUT_VOLTAGE_REGULATION_ACTIVE_I(st[11]), .THERMAL_REGULATION_ACTIVE_I(st[10]),
    .VIN_ABOVE_LOCKOUT_I(st[9]), .VIN_ABOVE_BAT_MARGIN_I(st[8]), .VIN_BELOW_OVP_I(st[7]),
    .INPUT_OVERVOLTAGE_FAULT_I(st[6]), .BATTERY_OVERCURRENT_FAULT_I(st[5]),
    .BAT_BELOW_LOCKOUT_I(st[4]), .TS_ABOVE_COLD_I(st[3]), .TS_ABOVE_COOL_I(st[2]),
    .TS_BELOW_WARM_I(st[1]), .TS_BELOW_HOT_I(st[0]), .CHARGE_SUSPEND_O(zone[2]),
    .CURRENT_REDUCE_O(zone[1]), .VOLTAGE_REDUCE_O(zone[0]), .CHARGE_PATH_STATUS_O(cp),
    .FAULT_TEMP_STATUS_O(ft));
  // expected register words from the input pattern
  function [7:0] exp_cp(input [15:0] s);
    exp_cp = {1'b0, s[15:10], &s[9:7]};
  endfunction
  function [7:0] exp_ft(input [15:0] s);
    exp_ft = {s[6], 1'b0, s[5:3], s[2] & ~s[3], s[1] & ~s[0], s[0]};
  endfunction
  task chk(input string n, input [7:0] e, input [7:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("BAD %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // one edge of latency, so look a full cycle later
  task apply(input [15:0] v);
    reg [7:0] f;
    begin
      @(negedge clk);
      st = v;
      @(negedge clk);
      f = exp_ft(v);
      chk("charge path", exp_cp(v), cp);
      chk("fault temp", f, ft);
      chk("zone requests", {5'h00, f[3] | f[0], f[2], f[1]}, {5'h00, zone});
    end
  endtask
  task put(input [7:0] b);
    reg [7:0] r;
    begin
      csr_i2c_host_i.xfer(b, 1'b1, r, a);
      chk("target ack", 8'h00, {7'h00, a});
    end
  endtask
  task rd2(input [7:0] ptr, input [7:0] e0, input [7:0] e1);
    begin
      csr_i2c_host_i.start;
      put({`CSR_DEV_ADDR, 1'b0});
      put(ptr);
      csr_i2c_host_i.start;
      put({`CSR_DEV_ADDR, 1'b1});
      csr_i2c_host_i.xfer(8'hFF, 1'b0, d0, a);
      csr_i2c_host_i.xfer(8'hFF, 1'b1, d1, a);
      csr_i2c_host_i.stop;
      chk("read byte 0", e0, d0);
      chk("read byte 1", e1, d1);
    end
  endtask
  task test_loops;
    integer i;
    begin
      for (i = 0; i < 6; i = i + 1) apply(16'h0400 << i);
      for (i = 0; i < 8; i = i + 1) apply({6'h00, i[2:0], 7'h00});
      $display("test_loops done");
    end
  endtask
  task test_faults_zones;
    begin
      apply(16'h0040);
      apply(16'h0020);
      apply(16'h0010);
      apply(16'h000C);
      apply(16'h0004);
      apply(16'h0002);
      apply(16'h0003);
      apply(16'h0000);
      $display("test_faults_zones done");
    end
  endtask
  // reads twice, write attempt, unmapped place, pointer wrap, stranger address
  task test_bus;
    begin
      apply(16'hB7D4);
      rd2(8'h00, exp_cp(st), exp_ft(st));
      rd2(8'h00, exp_cp(st), exp_ft(st));
      csr_i2c_host_i.start;
      put({`CSR_DEV_ADDR, 1'b0});
      put(8'h00);
      put(8'hFF);
      csr_i2c_host_i.stop;
      rd2(8'h00, exp_cp(st), exp_ft(st));
      rd2(8'hFF, 8'h00, exp_cp(st));
      rd2(8'h01, exp_ft(st), 8'h00);
      csr_i2c_host_i.start;
      csr_i2c_host_i.xfer({`CSR_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, d0, a);
      csr_i2c_host_i.stop;
      chk("stranger ack", 8'h01, {7'h00, a});
      $display("test_bus done");
    end
  endtask
  // mid-run reset clears the status and zone outputs and releases the data line; the pointer restarts at the first register
  task test_reset;
    begin
      apply(16'h0808);
      @(negedge clk);
      rst_n = 1'b0;
      @(negedge clk);
      chk("reset charge path", 8'h00, cp);
      chk("reset fault temp", 8'h00, ft);
      chk("reset pins", 8'h01, {4'h0, zone, oe_n});
      rst_n = 1'b1;
      @(negedge clk);
      chk("charge path after reset", exp_cp(st), cp);
      chk("fault temp after reset", exp_ft(st), ft);
      csr_i2c_host_i.start;
      put({`CSR_DEV_ADDR, 1'b1});
      csr_i2c_host_i.xfer(8'hFF, 1'b1, d0, a);
      csr_i2c_host_i.stop;
      chk("pointer after reset", exp_cp(st), d0);
      $display("test_reset done");
    end
  endtask
  task wrap_up;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    test_loops;
    test_faults_zones;
    test_bus;
    test_reset;
    wrap_up;
  end
  // hang guard, about thirteen times the expected run
  initial begin
    #400000;
    failures = failures + 1;
    wrap_up;
  end
endmodule // tb_csr_status_top
bind csr_status_top csr_status_props csr_status_props_i (.*);
